// ==== crs_master_model.sv ====
// bus master model that drives the backplane pins toward the configuration slave
`timescale 1ns/1ps
`default_nettype none
module crs_master_model #(
  parameter logic [5:0] AM = 6'h2F  // configuration space modifier
) (
  input  wire logic                mclk,     // board clock
  output var crs_pkg::crs_bus_in_t bus,      // pins driven toward the slave
  input  wire logic [31:0]         d_line,   // resolved data lines
  input  wire logic                dtack_l,  // resolved acknowledge line
  input  wire logic                berr_l,   // resolved bus error line
  input  wire logic                retry_l   // resolved retry line
);
  // released lines float to the terminator level
  initial bus = '1;

  // md 0 byte, 1 quad, 2 byte keeping the address strobe low afterwards
  // rsp 0 ack, 1 bus error, 2 retry, 3 no answer
  task automatic cycle(input logic [23:0] a, input logic wr, input logic [7:0] wd,
                       input logic ign, input logic [1:0] md, output logic [7:0] rd,
                       output logic [1:0] rsp, output logic [31:0] wrd);
    int n;
    n = 0;
    @(posedge mclk);
    bus.addr    <= a[23:1];
    bus.am      <= AM;
    bus.iack_n  <= 1'b1;
    bus.lword_n <= (md != 2'h1);
    bus.write_n <= ~wr;
    bus.data    <= wr ? {24'hFFFFFF, wd} : 32'hFFFFFFFF;
    bus.as_n    <= 1'b0;
    bus.ds_n    <= (md == 2'h1) ? 2'b00 : 2'b10;
    do begin
      @(posedge mclk);
      n++;
    end while (dtack_l && berr_l && (ign || retry_l) && n < 40);
    rd  = d_line[7:0];
    wrd = d_line;
    rsp = !dtack_l ? 2'd0 : !berr_l ? 2'd1 : (!retry_l && !ign) ? 2'd2 : 2'd3;
    if (md == 2'h2) begin
      bus.ds_n <= 2'b11;
    end else begin
      bus <= '1;
    end
    repeat (8) @(posedge mclk);
  endtask : cycle
endmodule : crs_master_model
`default_nettype wire

// ==== crs_pkg.sv ====
// constants, field layout and pin carrier for the configuration space slave
package crs_pkg;

  // byte offsets inside the board's 512 KB configuration region
  localparam int          OFF_W          = 19;
  localparam logic [18:0] OFF_CHECKSUM   = 19'h00003;
  localparam logic [18:0] OFF_LENGTH     = 19'h00007;
  localparam logic [18:0] OFF_ROM_WIDTH  = 19'h00013;
  localparam logic [18:0] OFF_AREA_WIDTH = 19'h00017;
  localparam logic [18:0] OFF_SPEC       = 19'h0001B;
  localparam logic [18:0] OFF_MARK_FIRST = 19'h0001F;
  localparam logic [18:0] OFF_MARK_SECND = 19'h00023;
  localparam logic [18:0] OFF_MAKER      = 19'h00027;
  localparam logic [18:0] OFF_BOARD      = 19'h00033;
  localparam logic [18:0] OFF_TEXT       = 19'h00053;
  localparam logic [18:0] OFF_PROG       = 19'h0007F;
  localparam logic [18:0] OFF_USER       = 19'h00080;
  localparam logic [18:0] OFF_BIT_CLEAR  = 19'h7FFF7;
  localparam logic [18:0] OFF_BIT_SET    = 19'h7FFFB;
  localparam logic [18:0] OFF_REGION     = 19'h7FFFF;

  // rom entries sit on every fourth byte
  localparam logic [18:0] ROM_STRIDE     = 19'h00004;
  // number of strided header bytes from the length field up to the program code
  localparam int          HDR_SLOTS      = 31;

  // bit positions of the set/clear control bytes
  localparam int          BIT_RESET      = 7;
  localparam int          BIT_SYSFAIL    = 6;
  localparam int          BIT_FAILED     = 5;
  // region number field of the region select byte
  localparam int          REGION_LSB     = 3;
  localparam int          REGION_W       = 5;

  // access width codes
  localparam logic [7:0]  WIDTH_BYTE_4TH = 8'h81;
  localparam logic [7:0]  WIDTH_BYTE_2ND = 8'h82;
  localparam logic [7:0]  WIDTH_D16      = 8'h83;
  localparam logic [7:0]  WIDTH_D32      = 8'h84;

  // valid rom marker bytes
  localparam logic [7:0]  MARK_FIRST     = 8'h43;
  localparam logic [7:0]  MARK_SECOND    = 8'h52;

  // length limits of the checksummed area
  localparam logic [23:0] LENGTH_MIN     = 24'h00001F;
  localparam logic [23:0] LENGTH_MAX     = 24'h07FFF0;

  // reset values
  localparam logic [4:0]  REGION_RESET   = 5'h01;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  // backplane inputs as seen at the pins (active low strobes)
  typedef struct packed {
    logic [23:1] addr;
    logic [5:0]  am;
    logic        as_n;
    logic [1:0]  ds_n;
    logic        lword_n;
    logic        write_n;
    logic        iack_n;
    logic [31:0] data;
  } crs_bus_in_t;

endpackage : crs_pkg

// ==== crs_slave.sv ====
// configuration rom and control/status slave on the asynchronous backplane
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: decode 32 regions by A23..A19
// RL2: A18..A1 pick location inside region
// RL3: D08(O), D08(EO), D16, D32 accesses served
// RL4: one 512 KB region, rom low, registers high
// RL5: rom readable bytewise every fourth byte from 0x03
// RL6: region select at top, bits 7..3, 1..31
// RL7: bit-set writes ones set reset/sysfail
// RL8: bit-clear writes ones clear reset/sysfail
// RL9: bit 5 reads failed, writes ignored
// RL10: reset mode leaves bus behaviour untouched
// RL11: byte 0x03 holds two's complement checksum
// RL12: three-byte length, msb first, 0x1F..0x7FFF0
// RL13: byte 0x13 gives rom access width
// RL14: byte 0x17 gives register area width
// RL15: marker bytes 0x43 and 0x52
// RL16: maker id and board_identifier bytes
// RL17: program code at 0x7F, user area 0x80
// RL18: busy or deadlock answered with retry; code retries on res_busy only, res_deadlock alone is acknowledged
// RL19: ignored retry ends in dtack or berr
// RL20: master ends cycle on seeing retry
// RL21: retry only in address phase of block
// RL22: master yields bus after honoured retry
// RL23: one flop per control state, both read
module crs_slave #(
  parameter logic [5:0]  CFG_AM      = 6'h2F,      // address modifier of config space
  parameter logic [23:0] ROM_LENGTH  = 24'h00001F, // bytes covered by the checksum
  parameter logic [7:0]  ROM_WIDTH   = 8'h81,      // rom access width code
  parameter logic [7:0]  AREA_WIDTH  = 8'h81,      // register area access width code
  parameter logic [7:0]  SPEC_ID     = 8'h01,      // space layout version
  parameter logic [23:0] MAKER_ID    = 24'h5A5A01, // arbitrary value
  parameter logic [31:0] BOARD_IDENTIFIER    = 32'h00C0FFEE, // arbitrary value
  parameter logic [23:0] TEXT_PTR    = 24'h000000, // no text string
  parameter logic [7:0]  PROG_CODE   = 8'h01,      // id rom only
  parameter logic [4:0]  REGION_INIT = crs_pkg::REGION_RESET
) (
  input  wire logic                 mclk,           // 20 MHz board clock
  input  wire logic                 arst_n,         // asynchronous reset
  input  wire crs_pkg::crs_bus_in_t bus_in,         // backplane pins in
  output logic [31:0]               data_out,       // read data to pins
  output logic                      data_oe,        // data lines driven
  output logic                      dtack_n_out,    // acknowledge level
  output logic                      dtack_oe,       // acknowledge driven
  output logic                      berr_n_out,     // bus error level
  output logic                      berr_oe,        // bus error driven
  output logic                      retry_n_out,    // retry level
  output logic                      retry_oe,       // retry driven
  output logic                      sysfail_n_out,  // failure line level
  output logic                      sysfail_oe,     // failure line driven
  input  wire logic                 res_busy,       // addressed resource busy
  input  wire logic                 res_deadlock,   // deadlock detected
  input  wire logic                 board_failed,   // board self test failed
  output logic                      reset_mode,     // board held in reset mode
  output logic                      sysfail_enable, // failure driver enabled
  output logic [4:0]                region_number   // selected region
);

  // handshake states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ACK   = 6'b000010,
    ST_RETRY = 6'b000100,
    ST_BERR  = 6'b001000,
    ST_END   = 6'b010000,
    ST_REL   = 6'b100000
  } crs_state_t;

  crs_pkg::crs_bus_in_t bus_meta;     // first synchroniser stage
  crs_pkg::crs_bus_in_t bus_s;        // second stage, safe to use
  crs_state_t           state;        // handshake state
  crs_state_t           next_state;   // next handshake state
  logic                 first_phase;  // no data phase yet under this strobe
  logic                 retry_was;    // retry was shown this cycle
  logic                 berr_flag;    // cycle answered with bus error
  logic                 selected;     // address decodes to this board
  logic                 ds_any;       // any data strobe low
  logic                 start;        // data phase request
  logic                 commit;       // access performed this edge
  logic [18:0]          wr_off;       // byte addressed on lane D7..D0
  logic [18:0]          grp_off;      // base of addressed 4-byte group
  logic [31:0]          next_rdata;   // read word for this access
  logic [7:0]           wr_byte;      // write data on lane D7..D0

  // checksum over the strided header from the length field on
  function automatic logic [7:0] hdr_byte(input logic [18:0] off);
    logic [7:0] v;
    v = crs_pkg::BYTE_ZERO;
    case (off)
      // RL12: length msb first
      crs_pkg::OFF_LENGTH:                               v = ROM_LENGTH[23:16];
      crs_pkg::OFF_LENGTH + crs_pkg::ROM_STRIDE:         v = ROM_LENGTH[15:8];
      crs_pkg::OFF_LENGTH + crs_pkg::ROM_STRIDE * 19'h2: v = ROM_LENGTH[7:0];
      // RL13: rom width code
      crs_pkg::OFF_ROM_WIDTH:                            v = ROM_WIDTH;
      // RL14: register area width
      crs_pkg::OFF_AREA_WIDTH:                           v = AREA_WIDTH;
      crs_pkg::OFF_SPEC:                                 v = SPEC_ID;
      // RL15: valid marker bytes
      crs_pkg::OFF_MARK_FIRST:                           v = crs_pkg::MARK_FIRST;
      crs_pkg::OFF_MARK_SECND:                           v = crs_pkg::MARK_SECOND;
      // RL16: maker and board ids
      crs_pkg::OFF_MAKER:                                v = MAKER_ID[23:16];
      crs_pkg::OFF_MAKER + crs_pkg::ROM_STRIDE:          v = MAKER_ID[15:8];
      crs_pkg::OFF_MAKER + crs_pkg::ROM_STRIDE * 19'h2:  v = MAKER_ID[7:0];
      crs_pkg::OFF_BOARD:                                v = BOARD_IDENTIFIER[31:24];
      crs_pkg::OFF_BOARD + crs_pkg::ROM_STRIDE:          v = BOARD_IDENTIFIER[23:16];
      crs_pkg::OFF_BOARD + crs_pkg::ROM_STRIDE * 19'h2:  v = BOARD_IDENTIFIER[15:8];
      crs_pkg::OFF_BOARD + crs_pkg::ROM_STRIDE * 19'h3:  v = BOARD_IDENTIFIER[7:0];
      crs_pkg::OFF_TEXT:                                 v = TEXT_PTR[23:16];
      crs_pkg::OFF_TEXT + crs_pkg::ROM_STRIDE:           v = TEXT_PTR[15:8];
      crs_pkg::OFF_TEXT + crs_pkg::ROM_STRIDE * 19'h2:   v = TEXT_PTR[7:0];
      // RL17: program code byte
      crs_pkg::OFF_PROG:                                 v = PROG_CODE;
      default:                                     v = crs_pkg::BYTE_ZERO;
    endcase
    return v;
  endfunction : hdr_byte

  // sum of the covered bytes, negated so the total comes to zero
  function automatic logic [7:0] calc_checksum();
    logic [7:0]  sum;
    logic [18:0] off;
    sum = crs_pkg::BYTE_ZERO;
    off = crs_pkg::OFF_LENGTH;
    for (int i = 0; i < crs_pkg::HDR_SLOTS; i++) begin
      if (24'(i) < ROM_LENGTH) begin
        sum = sum + hdr_byte(off);
      end
      off = off + crs_pkg::ROM_STRIDE;
    end
    return 8'(~sum + 8'h01);
  endfunction : calc_checksum

  // RL11: checksum byte
  localparam logic [7:0] ROM_CHECKSUM = calc_checksum();

  // full read map: rom at the bottom, control bytes at the top
  function automatic logic [7:0] rd_byte(input logic [18:0] off);
    logic [7:0] v;
    v = crs_pkg::BYTE_ZERO;
    // RL4: rom low, control area high
    if (off == crs_pkg::OFF_CHECKSUM) begin
      v = ROM_CHECKSUM;
    end else if (off < crs_pkg::OFF_USER) begin
      v = hdr_byte(off);
    end else if (off == crs_pkg::OFF_REGION) begin
      v = {region_number, 3'h0};
    end else if (off == crs_pkg::OFF_BIT_SET || off == crs_pkg::OFF_BIT_CLEAR) begin
      // RL23: both registers read the same flops
      v = {reset_mode, sysfail_enable, board_failed, 5'h00};
    end
    return v;
  endfunction : rd_byte

  // two-flop synchroniser on every backplane input
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_meta <= '1;
      bus_s    <= '1;
    end else begin
      bus_meta <= bus_in;
      bus_s    <= bus_meta;
    end
  end

  // address decode and request detect
  always_comb begin
    // RL1: region by the top five address bits
    selected = (bus_s.am == CFG_AM) && bus_s.iack_n && !bus_s.as_n &&
               (bus_s.addr[23:19] == region_number);
    ds_any   = !bus_s.ds_n[0] || !bus_s.ds_n[1];
    start    = selected && ds_any;
  end

  // RL2: location from A18..A1 and lword_n
  always_comb begin
    grp_off = {bus_s.addr[18:2], 2'b00};
    wr_off  = !bus_s.lword_n ? {bus_s.addr[18:2], 2'b11} : {bus_s.addr[18:1], 1'b1};
    wr_byte = bus_s.data[7:0];
  end

  // RL3: lane placement for byte, double byte and quad byte reads
  always_comb begin
    if (!bus_s.lword_n) begin
      next_rdata = {rd_byte(grp_off), rd_byte(grp_off | 19'h00001),
                    rd_byte(grp_off | 19'h00002), rd_byte(grp_off | 19'h00003)};
    end else begin
      // RL5: odd byte on D7..D0 for byte reads
      next_rdata = {16'h0000, rd_byte({bus_s.addr[18:1], 1'b0}),
                    rd_byte({bus_s.addr[18:1], 1'b1})};
    end
  end

  // next handshake state
  always_comb begin
    next_state = state;
    commit     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          // RL21: retry only before the first data phase
          if (res_busy && first_phase) begin
            next_state = ST_RETRY;
          end else if (!res_busy) begin
            next_state = ST_ACK;
            commit     = 1'b1;
          end
        end
      end
      ST_RETRY: begin
        // RL19: master kept the cycle open
        if (!ds_any) begin
          next_state = ST_REL;
        end else if (res_deadlock) begin
          next_state = ST_BERR;
        end else if (!res_busy) begin
          next_state = ST_ACK;
          commit     = 1'b1;
        end
      end
      ST_ACK, ST_BERR: begin
        // hold the answer until the strobes rise
        if (!ds_any) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        next_state = ST_REL;
      end
      ST_REL: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // address phase tracking, retry and bus error memory
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      first_phase <= 1'b1;
      retry_was   <= 1'b0;
      berr_flag   <= 1'b0;
    end else begin
      if (bus_s.as_n) begin
        first_phase <= 1'b1;
      end else if (commit) begin
        first_phase <= 1'b0;
      end
      if (next_state == ST_RETRY) begin
        retry_was <= 1'b1;
      end else if (next_state == ST_IDLE) begin
        retry_was <= 1'b0;
      end
      if (next_state == ST_BERR) begin
        berr_flag <= 1'b1;
      end else if (next_state == ST_IDLE) begin
        berr_flag <= 1'b0;
      end
    end
  end

  // read data latch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= 32'h00000000;
    end else if (commit) begin
      data_out <= next_rdata;
    end
  end

  // RL6: region select, only legal region numbers stored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      region_number <= REGION_INIT;
    end else if (commit && !bus_s.write_n && !bus_s.ds_n[0] &&
                 wr_off == crs_pkg::OFF_REGION &&
                 wr_byte[7:crs_pkg::REGION_LSB] != 5'h00) begin
      region_number <= wr_byte[7:crs_pkg::REGION_LSB];
    end
  end

  // control flops written through the set and clear bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_mode     <= 1'b0;
      sysfail_enable <= 1'b0;
    end else if (commit && !bus_s.write_n && !bus_s.ds_n[0]) begin
      // RL7: ones set, zeros ignored
      if (wr_off == crs_pkg::OFF_BIT_SET) begin
        if (wr_byte[crs_pkg::BIT_RESET]) begin
          reset_mode <= 1'b1;
        end
        if (wr_byte[crs_pkg::BIT_SYSFAIL]) begin
          sysfail_enable <= 1'b1;
        end
      end
      // RL8: ones clear, zeros ignored
      if (wr_off == crs_pkg::OFF_BIT_CLEAR) begin
        if (wr_byte[crs_pkg::BIT_RESET]) begin
          reset_mode <= 1'b0;
        end
        if (wr_byte[crs_pkg::BIT_SYSFAIL]) begin
          sysfail_enable <= 1'b0;
        end
      end
    end
  end

  // pin drive: reset_mode feeds nothing on the bus side
  always_comb begin
    // RL10: bus handshake independent of reset mode
    data_oe       = (state == ST_ACK) && bus_s.write_n;
    dtack_oe      = ((state == ST_ACK) || (state == ST_END) || (state == ST_REL)) &&
                    !berr_flag;
    dtack_n_out   = (state == ST_REL);
    berr_oe       = ((state == ST_BERR) || (state == ST_END) || (state == ST_REL)) &&
                    berr_flag;
    berr_n_out    = (state == ST_REL);
    // RL18: retry low while the resource is busy before the first data phase
    retry_oe      = (state == ST_RETRY) ||
                    (retry_was && ((state == ST_ACK) || (state == ST_BERR)));
    retry_n_out   = (state != ST_RETRY);
    // RL9: failed flag only from the board
    sysfail_oe    = sysfail_enable && board_failed;
    sysfail_n_out = 1'b0;
  end

  // checks

  a_ack_berr_excl: assert property (@(posedge mclk) disable iff (!arst_n) // RL19
    !(dtack_oe && !dtack_n_out && berr_oe && !berr_n_out))
    else $error("dtack and berr driven low together");

  a_retry_addr_phase: assert property (@(posedge mclk) disable iff (!arst_n) // RL21
    (state == ST_IDLE && start && res_busy && !first_phase) |=> state != ST_RETRY)
    else $error("retry issued in a data phase");

  a_busy_retry: assert property (@(posedge mclk) disable iff (!arst_n) // RL18
    (state == ST_IDLE && start && res_busy && first_phase) |=> retry_oe && !retry_n_out)
    else $error("busy resource not answered with retry");

  a_deadlock_berr: assert property (@(posedge mclk) disable iff (!arst_n) // RL19
    (state == ST_RETRY && ds_any && res_deadlock) |=> ##1 (berr_oe && !berr_n_out))
    else $error("deadlock not answered with berr");

  a_busy_free_ack: assert property (@(posedge mclk) disable iff (!arst_n) // RL19
    (state == ST_RETRY && ds_any && !res_deadlock && !res_busy) |=> ##1 (dtack_oe && !dtack_n_out))
    else $error("freed resource not acknowledged");

  a_set_reset: assert property (@(posedge mclk) disable iff (!arst_n) // RL7
    (commit && !bus_s.write_n && !bus_s.ds_n[0] && wr_off == crs_pkg::OFF_BIT_SET &&
     wr_byte[crs_pkg::BIT_RESET]) |=> reset_mode)
    else $error("bit-set write did not enter reset mode");

  a_clear_sysfail: assert property (@(posedge mclk) disable iff (!arst_n) // RL8
    (commit && !bus_s.write_n && !bus_s.ds_n[0] && wr_off == crs_pkg::OFF_BIT_CLEAR &&
     wr_byte[crs_pkg::BIT_SYSFAIL] && !(wr_off == crs_pkg::OFF_BIT_SET)) |=> !sysfail_enable)
    else $error("bit-clear write did not disable the failure driver");

  a_region_legal: assert property (@(posedge mclk) disable iff (!arst_n) // RL6
    $changed(region_number) |-> region_number != 5'h00)
    else $error("region select took region zero");

  a_data_released: assert property (@(posedge mclk) disable iff (!arst_n) // RL3
    (state == ST_ACK && !ds_any) |=> !data_oe && dtack_oe && !dtack_n_out)
    else $error("data not released before dtack rises");

endmodule : crs_slave

`default_nettype wire

// ==== crs_slave_tb_top.sv ====
// self-checking bench for the configuration space slave
`timescale 1ns/1ps
`default_nettype none
module crs_slave_tb_top;
  localparam logic [23:0] P_LEN   = 24'h00001F;   // checksummed length
  localparam logic [7:0]  P_RW    = 8'h83;        // rom width code
  localparam logic [7:0]  P_AW    = 8'h84;        // register area width code
  localparam logic [7:0]  P_SPEC  = 8'h01;        // layout version
  localparam logic [23:0] P_MAKER = 24'h123456;   // arbitrary value
  localparam logic [31:0] P_BOARD = 32'h0A0B0C0D; // arbitrary value
  localparam logic [23:0] P_TEXT  = 24'h000100;   // text pointer
  localparam logic [7:0]  P_PROG  = 8'h50;        // user program code

  logic                 mclk = 1'b0;         // 20 MHz clock
  logic                 arst_n = 1'b0;       // reset, active low
  logic                 res_busy = 1'b0;     // resource busy
  logic                 res_deadlock = 1'b0; // deadlock flag
  logic                 board_failed = 1'b0; // failure input
  crs_pkg::crs_bus_in_t bus;                 // pins from the master
  logic [31:0]          data_out;            // slave data
  logic                 data_oe, dtack_n_out, dtack_oe, berr_n_out, berr_oe;
  logic                 retry_n_out, retry_oe, sysfail_n_out, sysfail_oe;
  logic                 reset_mode, sysfail_enable;
  logic [4:0]           region_number;       // slave region
  logic [4:0]           region = 5'h01;      // region used by accesses
  logic [7:0]           rd, sum;             // read byte, running sum
  logic [1:0]           rsp;                 // response kind
  logic [1:0]           md = 2'h0;           // master cycle kind
  logic [31:0]          word;                // full read word
  logic [18:0]          o;                   // header offset
  int                   err_count = 0;
  int                   check_count = 0;

  // terminated open-collector lines
  wire logic [31:0] d_line  = data_oe ? data_out : 32'hFFFFFFFF;
  wire logic        dtack_l = ~dtack_oe | dtack_n_out;
  wire logic        berr_l  = ~berr_oe | berr_n_out;
  wire logic        retry_l = ~retry_oe | retry_n_out;

  // clock
  always #25 mclk = ~mclk;

  crs_slave #(.ROM_LENGTH(P_LEN), .ROM_WIDTH(P_RW), .AREA_WIDTH(P_AW), .SPEC_ID(P_SPEC),
    .MAKER_ID(P_MAKER), .BOARD_IDENTIFIER(P_BOARD), .TEXT_PTR(P_TEXT), .PROG_CODE(P_PROG)) dut (
    .mclk(mclk), .arst_n(arst_n), .bus_in(bus), .data_out(data_out), .data_oe(data_oe),
    .dtack_n_out(dtack_n_out), .dtack_oe(dtack_oe), .berr_n_out(berr_n_out),
    .berr_oe(berr_oe), .retry_n_out(retry_n_out), .retry_oe(retry_oe),
    .sysfail_n_out(sysfail_n_out), .sysfail_oe(sysfail_oe), .res_busy(res_busy),
    .res_deadlock(res_deadlock), .board_failed(board_failed), .reset_mode(reset_mode),
    .sysfail_enable(sysfail_enable), .region_number(region_number));

  crs_master_model master (.mclk(mclk), .bus(bus), .d_line(d_line), .dtack_l(dtack_l),
    .berr_l(berr_l), .retry_l(retry_l));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one access in the current region
  task automatic acc(input logic [18:0] off, input logic wr, input logic [7:0] wd,
                     input logic ign);
    master.cycle({region, off}, wr, wd, ign, md, rd, rsp, word);
  endtask : acc

  // read with acknowledge and masked value
  task automatic rdc(input logic [18:0] off, input logic [7:0] exp, input logic [7:0] m);
    acc(off, 1'b0, 8'h00, 1'b0);
    chk(32'(rsp), 32'h0);
    chk(32'(rd & m), 32'(exp & m));
  endtask : rdc

  // write with acknowledge
  task automatic wrc(input logic [18:0] off, input logic [7:0] wd);
    acc(off, 1'b1, wd, 1'b0);
    chk(32'(rsp), 32'h0);
  endtask : wrc

  // expected header byte at a strided offset
  function automatic logic [7:0] hdr(input logic [18:0] a);
    case (a)
      19'h00007: return P_LEN[23:16];
      19'h0000B: return P_LEN[15:8];
      19'h0000F: return P_LEN[7:0];
      19'h00013: return P_RW;
      19'h00017: return P_AW;
      19'h0001B: return P_SPEC;
      19'h0001F: return 8'h43;
      19'h00023: return 8'h52;
      19'h00027: return P_MAKER[23:16];
      19'h0002B: return P_MAKER[15:8];
      19'h0002F: return P_MAKER[7:0];
      19'h00033: return P_BOARD[31:24];
      19'h00037: return P_BOARD[23:16];
      19'h0003B: return P_BOARD[15:8];
      19'h0003F: return P_BOARD[7:0];
      19'h00053: return P_TEXT[23:16];
      19'h00057: return P_TEXT[15:8];
      19'h0005B: return P_TEXT[7:0];
      19'h0007F: return P_PROG;
      default:   return 8'h00;
    endcase
  endfunction : hdr

  // print counts and verdict, end the run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    finish_test();
  end

  // test sequence
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(32'(region_number), 32'h1);
    chk(32'({reset_mode, sysfail_enable, sysfail_oe}), 32'h0);
    // header walk on every fourth byte and checksum
    sum = 8'h00;
    for (int i = 0; i < 31; i++) begin
      o = crs_pkg::OFF_LENGTH + crs_pkg::ROM_STRIDE * 19'(i);
      rdc(o, hdr(o), 8'hFF);
      sum = sum + hdr(o);
    end
    rdc(crs_pkg::OFF_CHECKSUM, 8'h00 - sum, 8'hFF);
    wrc(crs_pkg::OFF_MARK_FIRST, 8'h00);
    rdc(crs_pkg::OFF_MARK_FIRST, 8'h43, 8'hFF);
    $display("test rom done");
    // set, clear and failed flag
    wrc(crs_pkg::OFF_BIT_SET, 8'hC0);
    chk(32'({reset_mode, sysfail_enable}), 32'h3);
    board_failed <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(32'({sysfail_oe, sysfail_n_out}), 32'h2);
    rdc(crs_pkg::OFF_BIT_SET, 8'hE0, 8'hE0);
    rdc(crs_pkg::OFF_BIT_CLEAR, 8'hE0, 8'hE0);
    wrc(crs_pkg::OFF_BIT_CLEAR, 8'h20);
    wrc(crs_pkg::OFF_BIT_SET, 8'h00);
    chk(32'({reset_mode, sysfail_enable}), 32'h3);
    wrc(crs_pkg::OFF_BIT_CLEAR, 8'h80);
    chk(32'({reset_mode, sysfail_enable}), 32'h1);
    wrc(crs_pkg::OFF_BIT_CLEAR, 8'h40);
    chk(32'({sysfail_enable, sysfail_oe}), 32'h0);
    board_failed <= 1'b0;
    rdc(crs_pkg::OFF_BIT_SET, 8'h00, 8'hE0);
    $display("test control done");
    // region move, old region silent, zero refused
    wrc(crs_pkg::OFF_REGION, 8'h28);
    chk(32'(region_number), 32'h5);
    acc(crs_pkg::OFF_MARK_FIRST, 1'b0, 8'h00, 1'b0);
    chk(32'(rsp), 32'h3);
    region = 5'h05;
    rdc(crs_pkg::OFF_MARK_SECND, 8'h52, 8'hFF);
    wrc(crs_pkg::OFF_REGION, 8'h00);
    rdc(crs_pkg::OFF_REGION, 8'h28, 8'hF8);
    // quad read of the top group: region byte on D7..D0
    md = 2'h1;
    acc(19'h7FFFC, 1'b0, 8'h00, 1'b0);
    md = 2'h0;
    chk(32'(rsp), 32'h0);
    chk(word, 32'h00000028);
    $display("test region done");
    // retry honoured, retry ignored on busy, then deadlock
    res_busy <= 1'b1;
    acc(crs_pkg::OFF_MARK_FIRST, 1'b0, 8'h00, 1'b0);
    chk(32'(rsp), 32'h2);
    fork
      acc(crs_pkg::OFF_MARK_FIRST, 1'b0, 8'h00, 1'b1);
      begin
        repeat (12) @(posedge mclk);
        res_busy <= 1'b0;
      end
    join
    chk(32'({rsp, rd}), 32'h043);
    res_busy <= 1'b1;
    res_deadlock <= 1'b1;
    acc(crs_pkg::OFF_MARK_FIRST, 1'b0, 8'h00, 1'b1);
    chk(32'(rsp), 32'h1);
    res_busy <= 1'b0;
    res_deadlock <= 1'b0;
    // a second data phase under one address strobe waits instead of retrying
    md = 2'h2;
    rdc(crs_pkg::OFF_MARK_FIRST, 8'h43, 8'hFF);
    md = 2'h0;
    res_busy <= 1'b1;
    fork
      acc(crs_pkg::OFF_MARK_FIRST, 1'b0, 8'h00, 1'b0);
      begin
        repeat (12) @(posedge mclk);
        res_busy <= 1'b0;
      end
    join
    chk(32'({rsp, rd}), 32'h043);
    $display("test retry done");
    finish_test();
  end
endmodule : crs_slave_tb_top
`default_nettype wire
